// ### src/dbfc_pkg.sv
// Package with constants and carriers for the dual bank flash command control
package dbfc_pkg;
    localparam int BANKS         = 2;
    localparam int ROW_BYTES     = 64;
    localparam int ROWS          = 1024;
    localparam int SECTOR_ROWS   = 8;
    localparam int ADDR_W        = 17;
    localparam int BANK_ADDR_W   = 16;
    localparam int ROW_IDX_LSB   = 6;
    localparam int ROW_IDX_W     = 10;
    localparam int SECTOR_LSB    = 9;
    localparam int SECTOR_W      = 7;
    localparam int BANK_BIT      = 16;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    // Command codes
    localparam logic [7:0] CMD_VERIFY  = 8'h05;
    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_SECTOR  = 8'h40;
    localparam logic [7:0] CMD_MASS    = 8'h41;
    // Operation times
    localparam int PROG_TIME_NS  = 20000;
    localparam int ERASE_TIME_NS = 20000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 24;

    // Sequence steps of the three-step launch
    typedef enum logic [2:0] {
        DBFC_SEQ_IDLE = 3'b001,
        DBFC_SEQ_DATA = 3'b010,
        DBFC_SEQ_CMD  = 3'b100
    } dbfc_seq_e;

    // Array engine states
    typedef enum logic [2:0] {
        DBFC_ENG_IDLE = 3'b001,
        DBFC_ENG_RUN  = 3'b010,
        DBFC_ENG_DONE = 3'b100
    } dbfc_eng_e;

    // One queued or executing command
    typedef struct packed {
        logic                   valid;
        logic [7:0]             cmd;
        logic [BANK_ADDR_W-1:0] addr;
        logic [15:0]            data;
    } dbfc_cmd_s;

    // Host read request
    typedef struct packed {
        logic              req;
        logic              word;
        logic [ADDR_W-1:0] addr;
    } dbfc_rd_s;
endpackage : dbfc_pkg

// ### src/dbfc_bank.sv
// One flash array with its command engine and read port
`timescale 1ns/100ps
`default_nettype none
module dbfc_bank
    import dbfc_pkg::*;
#(
    parameter int PROG_CNT  = PROG_CYCLES,
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int WORDS     = 32768
) (
    // Clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    // Command from the launcher
    input  wire dbfc_pkg::dbfc_cmd_s    cmd_i,
    output logic                        busy_o,
    output logic                        done_o,
    output logic                        verify_ok_o,
    // Word read port, address is a word index
    input  wire logic [BANK_ADDR_W-2:0] rd_word_i,
    output logic [15:0]                 rd_data_o
);
    import dbfc_pkg::*;

    localparam int SECT_WORDS = SECTOR_ROWS * ROW_BYTES / 2;

    logic [15:0]            mem_q [WORDS];
    dbfc_eng_e              st_q, st_d;
    logic [CNT_W-1:0]       cnt_q, cnt_d;
    dbfc_cmd_s              op_q, op_d;
    logic                   ok_q, ok_d;
    logic [BANK_ADDR_W-2:0] wi;
    logic [BANK_ADDR_W-2:0] sect_base;

    assign wi        = op_q.addr[BANK_ADDR_W-1:1];
    // Sector base aligned on eight rows of 64 bytes
    assign sect_base = {op_q.addr[BANK_ADDR_W-1:SECTOR_LSB], {(SECTOR_LSB-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////////
    // Engine next state: timing runs without host help
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        op_d = op_q;
        case (st_q)
            DBFC_ENG_IDLE: begin
                if (cmd_i.valid) begin
                    op_d = cmd_i;
                    st_d = DBFC_ENG_RUN;
                    cnt_d = (cmd_i.cmd == CMD_PROGRAM) ? CNT_W'(PROG_CNT - 1) :
                            (cmd_i.cmd == CMD_VERIFY) ? CNT_W'(0) : CNT_W'(ERASE_CNT - 1);
                end
            end
            DBFC_ENG_RUN: begin
                if (cnt_q == '0) begin
                    st_d = DBFC_ENG_DONE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            DBFC_ENG_DONE: begin
                st_d = DBFC_ENG_IDLE;
            end
            default: st_d = DBFC_ENG_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q  <= DBFC_ENG_IDLE;
            cnt_q <= '0;
            op_q  <= '0;
            ok_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            op_q  <= op_d;
            ok_q  <= ok_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array cells update at the end of the operation; no reset, storage only
    always_ff @(posedge mclk_i) begin
        if (st_q == DBFC_ENG_RUN && cnt_q == '0) begin
            if (op_q.cmd == CMD_PROGRAM) begin
                mem_q[wi] <= mem_q[wi] & op_q.data;
            end else if (op_q.cmd == CMD_MASS) begin
                for (int i = 0; i < WORDS; i++) begin
                    mem_q[i] <= ERASED_WORD;
                end
            end else if (op_q.cmd == CMD_SECTOR) begin
                for (int i = 0; i < SECT_WORDS; i++) begin
                    mem_q[sect_base + (BANK_ADDR_W-1)'(i)] <= ERASED_WORD;
                end
            end
        end
    end

    // Erase verify result, sampled whole-array compare
    always_comb begin
        ok_d = ok_q;
        if (st_q == DBFC_ENG_RUN && cnt_q == '0 && op_q.cmd == CMD_VERIFY) begin
            ok_d = 1'b1;
            for (int i = 0; i < WORDS; i++) begin
                if (mem_q[i] != ERASED_WORD) ok_d = 1'b0;
            end
        end
    end

    assign busy_o      = (st_q != DBFC_ENG_IDLE);
    assign done_o      = (st_q == DBFC_ENG_DONE);
    assign verify_ok_o = ok_q;
    assign rd_data_o   = mem_q[rd_word_i];

    ////////////////////////////////////////////////////////////////////////
    // Timing checks
    prog_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (st_q == DBFC_ENG_IDLE && cmd_i.valid && cmd_i.cmd == CMD_PROGRAM) |=> busy_o [*2])
        else $error("program ended too early");
    done_after_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        done_o |-> $past(busy_o))
        else $error("done without busy");
endmodule : dbfc_bank
`default_nettype wire

// ### src/dbfc_top.sv
// Top of the dual bank flash command control
// Functional notes
// - Memory is two independent arrays of 64 KB each, chosen by address bit 16.
// - Each array has 1024 rows of 64 bytes, row index taken from the array address.
// - A sector erase clears one aligned group of eight rows, 512 bytes.
// - Byte and aligned word reads answer in one cycle, odd word reads in two.
// - Byte, aligned word and odd address word reads are accepted and assembled.
// - Sector erase and whole array mass erase are both supported.
// - Erased cells read one and programming only clears bits to zero.
// - Both arrays may run operations at once, each with its own busy flag.
// - Reads of a busy array are not serviced; they return FFFF, or FF in the low byte when the second word of an odd read is busy, with the busy error flag set.
// - Per-array state is reached through one port chosen by a bank select.
// - Shared controls act on both arrays regardless of the bank select.
// - Operations launch only by an ordered address, data, command sequence.
// - Interrupt outputs flag command completion with no command queued behind it, and both command buffers empty.
// - After launch the timing of an operation runs internally to the end.
`timescale 1ns/100ps
`default_nettype none
module dbfc_top
    import dbfc_pkg::*;
#(
    parameter int PROG_CNT  = PROG_CYCLES,
    parameter int ERASE_CNT = ERASE_CYCLES
) (
    // Clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    // Read port
    input  wire dbfc_pkg::dbfc_rd_s     rd_i,
    output logic                        rd_valid_o,
    output logic [15:0]                 rd_data_o,
    output logic                        rd_busy_err_o,
    // Command sequence steps
    input  wire logic                   bank_sel_i,
    input  wire logic                   step_addr_i,
    input  wire logic [BANK_ADDR_W-1:0] step_addr_val_i,
    input  wire logic                   step_data_i,
    input  wire logic [15:0]            step_data_val_i,
    input  wire logic                   step_cmd_i,
    input  wire logic [7:0]             step_cmd_val_i,
    input  wire logic                   err_clr_i,
    // Status of the selected array, and the access error shared by both arrays
    output logic                        sel_busy_o,
    output logic                        sel_buf_empty_o,
    output logic                        sel_verify_ok_o,
    output logic                        access_err_o,
    // Shared event lines
    output logic                        cmd_done_irq_o,
    output logic                        buf_empty_irq_o
);
    import dbfc_pkg::*;

    dbfc_seq_e              seq_q  [BANKS];
    dbfc_seq_e              seq_d  [BANKS];
    dbfc_cmd_s              stg_q  [BANKS];
    dbfc_cmd_s              stg_d  [BANKS];
    dbfc_cmd_s              que_q  [BANKS];
    dbfc_cmd_s              que_d  [BANKS];
    dbfc_cmd_s              launch [BANKS];
    logic                   busy   [BANKS];
    logic                   done   [BANKS];
    logic                   vok    [BANKS];
    logic [BANK_ADDR_W-2:0] rword  [BANKS];
    logic [15:0]            rdat   [BANKS];
    logic                   err_q, err_d;
    logic                   bad_step;
    logic                   legal_cmd;
    logic                   sb;

    assign sb        = bank_sel_i;
    assign legal_cmd = (step_cmd_val_i == CMD_PROGRAM) || (step_cmd_val_i == CMD_SECTOR) ||
                       (step_cmd_val_i == CMD_MASS) || (step_cmd_val_i == CMD_VERIFY);

    ////////////////////////////////////////////////////////////////////////
    // Three step launch tracker and one-deep queue per array
    always_comb begin
        bad_step = 1'b0;
        for (int b = 0; b < BANKS; b++) begin
            seq_d[b]  = seq_q[b];
            stg_d[b]  = stg_q[b];
            que_d[b]  = que_q[b];
            launch[b] = '0;
            // Queued command moves on when the engine is free
            if (que_q[b].valid && !busy[b]) begin
                launch[b] = que_q[b];
                que_d[b]  = '0;
            end
        end
        case (seq_q[sb])
            DBFC_SEQ_IDLE: begin
                if (step_addr_i) begin
                    stg_d[sb].addr = step_addr_val_i;
                    seq_d[sb] = DBFC_SEQ_DATA;
                end else if (step_data_i || step_cmd_i) begin
                    bad_step = 1'b1;
                end
            end
            DBFC_SEQ_DATA: begin
                if (step_data_i) begin
                    stg_d[sb].data = step_data_val_i;
                    seq_d[sb] = DBFC_SEQ_CMD;
                end else if (step_addr_i || step_cmd_i) begin
                    bad_step = 1'b1;
                    seq_d[sb] = DBFC_SEQ_IDLE;
                end
            end
            DBFC_SEQ_CMD: begin
                // A full queue or an unknown code aborts, memory untouched
                if (step_cmd_i && legal_cmd && !que_q[sb].valid) begin
                    que_d[sb] = '{valid: 1'b1, cmd: step_cmd_val_i,
                                  addr: stg_q[sb].addr, data: stg_q[sb].data};
                    seq_d[sb] = DBFC_SEQ_IDLE;
                end else if (step_addr_i || step_data_i || step_cmd_i) begin
                    bad_step = 1'b1;
                    seq_d[sb] = DBFC_SEQ_IDLE;
                end
            end
            default: seq_d[sb] = DBFC_SEQ_IDLE;
        endcase
        // Set wins over clear
        err_d = bad_step | (err_q & ~err_clr_i);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int b = 0; b < BANKS; b++) begin
                seq_q[b] <= DBFC_SEQ_IDLE;
                stg_q[b] <= '0;
                que_q[b] <= '0;
            end
            err_q <= 1'b0;
        end else begin
            for (int b = 0; b < BANKS; b++) begin
                seq_q[b] <= seq_d[b];
                stg_q[b] <= stg_d[b];
                que_q[b] <= que_d[b];
            end
            err_q <= err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: odd word takes a second cycle to fetch the low byte
    logic                   rv_q, rv_d;
    logic [15:0]            rdat_q, rdat_d;
    logic                   berr_q, berr_d;
    logic                   mis_q, mis_d;
    logic [7:0]             hi_q, hi_d;
    logic [ADDR_W-1:0]      ra_q, ra_d;
    logic [ADDR_W-1:0]      ra;
    logic                   rbank;
    logic [15:0]            rw;

    // During the second cycle of an odd read the held address plus one drives the array
    assign ra    = mis_q ? ra_q + ADDR_W'(1) : rd_i.addr;
    assign rbank = ra[BANK_BIT];
    assign rw    = rdat[rbank];

    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            rword[b] = ra[BANK_ADDR_W-1:1];
        end
        rv_d   = 1'b0;
        rdat_d = rdat_q;
        berr_d = 1'b0;
        mis_d  = 1'b0;
        hi_d   = hi_q;
        ra_d   = ra_q;
        if (mis_q) begin
            // Second cycle: low byte from the next word
            rv_d = 1'b1;
            if (busy[rbank]) begin
                berr_d = 1'b1;
                rdat_d = {hi_q, ERASED_BYTE};
            end else begin
                rdat_d = {hi_q, rw[15:8]};
            end
        end else if (rd_i.req) begin
            if (busy[rbank]) begin
                rv_d = 1'b1;
                berr_d = 1'b1;
                rdat_d = ERASED_WORD;
            end else if (rd_i.word && rd_i.addr[0]) begin
                mis_d = 1'b1;
                hi_d  = rw[7:0];
                ra_d  = rd_i.addr;
            end else begin
                rv_d = 1'b1;
                if (rd_i.word) begin
                    rdat_d = rw;
                end else begin
                    rdat_d = {8'h00, rd_i.addr[0] ? rw[7:0] : rw[15:8]};
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rv_q   <= 1'b0;
            rdat_q <= '0;
            berr_q <= 1'b0;
            mis_q  <= 1'b0;
            hi_q   <= '0;
            ra_q   <= '0;
        end else begin
            rv_q   <= rv_d;
            rdat_q <= rdat_d;
            berr_q <= berr_d;
            mis_q  <= mis_d;
            hi_q   <= hi_d;
            ra_q   <= ra_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The two arrays
    for (genvar g = 0; g < BANKS; g++) begin : g_bank
        dbfc_bank #(
            .PROG_CNT  (PROG_CNT),
            .ERASE_CNT (ERASE_CNT),
            .WORDS     (ROWS * ROW_BYTES / 2)
        ) u_bank (
            .mclk_i      (mclk_i),
            .rst_n_i     (rst_n_i),
            .cmd_i       (launch[g]),
            .busy_o      (busy[g]),
            .done_o      (done[g]),
            .verify_ok_o (vok[g]),
            .rd_word_i   (rword[g]),
            .rd_data_o   (rdat[g])
        );
    end

    // Outputs; the event lines are shared over both arrays
    assign rd_valid_o      = rv_q;
    assign rd_data_o       = rdat_q;
    assign rd_busy_err_o   = berr_q;
    assign sel_busy_o      = busy[sb] | que_q[sb].valid;
    assign sel_buf_empty_o = ~que_q[sb].valid;
    assign sel_verify_ok_o = vok[sb];
    assign access_err_o    = err_q;
    assign cmd_done_irq_o  = (done[0] & ~que_q[0].valid) | (done[1] & ~que_q[1].valid);
    assign buf_empty_irq_o = ~que_q[0].valid & ~que_q[1].valid;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    seq_reject_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (seq_q[sb] == DBFC_SEQ_IDLE && step_cmd_i && !step_addr_i) |=> access_err_o)
        else $error("out of order step not flagged");
    aligned_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rd_i.req && !mis_q && !(rd_i.word && rd_i.addr[0])) |=> rd_valid_o)
        else $error("aligned read late");
    odd_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rd_i.req && !mis_q && rd_i.word && rd_i.addr[0] && !busy[rd_i.addr[BANK_BIT]])
        |=> !rd_valid_o ##1 rd_valid_o)
        else $error("odd read not two cycles");
    queue_move_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (que_q[0].valid && !busy[0]) |=> (!que_q[0].valid && busy[0]))
        else $error("queued command stuck");
    // Fixed bank index, so a bank select change cannot fake a rising edge
    launch_seq_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(que_q[0].valid) |-> $past(seq_q[0] == DBFC_SEQ_CMD))
        else $error("command queued without sequence");
    launch_seq_b1_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(que_q[1].valid) |-> $past(seq_q[1] == DBFC_SEQ_CMD))
        else $error("second array queued without sequence");
    busy_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rd_i.req && !mis_q && busy[rd_i.addr[BANK_BIT]]) |=> (rd_busy_err_o && rd_data_o == ERASED_WORD))
        else $error("busy array read served");
endmodule : dbfc_top
`default_nettype wire

// ### dv/dbfc_host_model.sv
// Host side model that drives reads and launch sequences
`timescale 1ns/100ps
`default_nettype none
module dbfc_host_model (
    // Clock and answers from the block
    input  wire logic                             mclk_i,
    input  wire logic                             rd_valid_i,
    input  wire logic [15:0]                      rd_data_i,
    input  wire logic                             rd_busy_err_i,
    input  wire logic                             sel_busy_i,
    // Requests toward the block
    output var  dbfc_pkg::dbfc_rd_s               rd_o,
    output var  logic                             bank_sel_o,
    output var  logic                             step_addr_o,
    output var  logic [dbfc_pkg::BANK_ADDR_W-1:0] addr_val_o,
    output var  logic                             step_data_o,
    output var  logic [15:0]                      data_val_o,
    output var  logic                             step_cmd_o,
    output var  logic [7:0]                       cmd_val_o
);
    import dbfc_pkg::*;

    // Quiet levels at time zero
    initial begin
        rd_o = '0;
        {bank_sel_o, step_addr_o, step_data_o, step_cmd_o} = 4'h0;
        {addr_val_o, data_val_o, cmd_val_o} = '0;
    end

    // Ordered address, data, command steps; released values inverted
    task automatic step(input logic b, input logic [15:0] a, input logic [15:0] d,
                        input logic [7:0] c);
        @(negedge mclk_i) begin bank_sel_o = b; step_addr_o = 1'b1; addr_val_o = a; end
        @(negedge mclk_i) begin step_addr_o = 1'b0; addr_val_o = ~a; step_data_o = 1'b1; data_val_o = d; end
        @(negedge mclk_i) begin step_data_o = 1'b0; data_val_o = ~d; step_cmd_o = 1'b1; cmd_val_o = c; end
        @(negedge mclk_i) begin step_cmd_o = 1'b0; cmd_val_o = ~c; end
        @(negedge mclk_i);
    endtask : step

    // Command step alone, out of order on purpose
    task automatic lone(input logic [7:0] c);
        @(negedge mclk_i) begin step_cmd_o = 1'b1; cmd_val_o = c; end
        @(negedge mclk_i) begin step_cmd_o = 1'b0; cmd_val_o = ~c; end
        @(negedge mclk_i);
    endtask : lone

    // One read; latency counted in cycles after the taking edge
    task automatic rd(input logic [16:0] a, input logic w, output logic [15:0] d,
                      output logic be, output int lat);
        d = 16'hXXXX;
        be = 1'bx;
        lat = -1;
        @(negedge mclk_i) begin rd_o.req = 1'b1; rd_o.word = w; rd_o.addr = a; end
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk_i);
            if (i == 0) begin rd_o.req = 1'b0; rd_o.addr = ~a; end
            if (rd_valid_i === 1'b1) begin d = rd_data_i; be = rd_busy_err_i; lat = i + 1; break; end
        end
        @(negedge mclk_i);
    endtask : rd

    // Bounded wait until the chosen array is quiet
    task automatic wait_idle(input logic b, output logic ok);
        ok = 1'b0;
        @(negedge mclk_i) bank_sel_o = b;
        for (int i = 0; i < 300; i++) begin
            @(negedge mclk_i);
            if (sel_busy_i === 1'b0) begin ok = 1'b1; break; end
        end
    endtask : wait_idle
endmodule : dbfc_host_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the dual bank flash command control
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dbfc_pkg::*;
    localparam int PC = 16;
    localparam int EC = 64;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, err_clr_i = 1'b0;
    dbfc_rd_s rd_s;
    logic rv, rbe, bsel, sa, sd, sc, sbusy, sbe, svok, aerr, dirq, eirq;
    logic [15:0] rdat, dval, av;
    logic [7:0] cval;
    int miscompares = 0, total_checks = 0, done_seen = 0;
    logic [7:0] mem [int];
    int progq[$];

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and host model
    always #12.5 mclk_i = ~mclk_i;
    dbfc_top #(.PROG_CNT(PC), .ERASE_CNT(EC)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rd_i(rd_s),
        .rd_valid_o(rv), .rd_data_o(rdat), .rd_busy_err_o(rbe), .bank_sel_i(bsel), .step_addr_i(sa),
        .step_addr_val_i(av), .step_data_i(sd), .step_data_val_i(dval), .step_cmd_i(sc),
        .step_cmd_val_i(cval), .err_clr_i(err_clr_i), .sel_busy_o(sbusy), .sel_buf_empty_o(sbe),
        .sel_verify_ok_o(svok), .access_err_o(aerr), .cmd_done_irq_o(dirq), .buf_empty_irq_o(eirq));
    dbfc_host_model host (.mclk_i(mclk_i), .rd_valid_i(rv), .rd_data_i(rdat), .rd_busy_err_i(rbe),
        .sel_busy_i(sbusy), .rd_o(rd_s), .bank_sel_o(bsel), .step_addr_o(sa), .addr_val_o(av),
        .step_data_o(sd), .data_val_o(dval), .step_cmd_o(sc), .cmd_val_o(cval));

    // Completion events counted at the sampling edge
    always @(posedge mclk_i) if (dirq === 1'b1) done_seen++;

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin miscompares++; $display("unexpected at %0t: got %h want %h", $time, s, e); end
    endtask : check

    function automatic logic [7:0] bt(int a);
        return mem.exists(a) ? mem[a] : ERASED_BYTE;
    endfunction : bt

    // Reads are big endian and bytes sit in the low half
    task automatic rd_chk(int a, logic w);
        logic [15:0] d;
        logic be;
        int lat;
        host.rd(a[16:0], w, d, be, lat);
        check(d, w ? {bt(a), bt(a + 1)} : {8'h00, bt(a)});
        check(16'(lat), (w && a[0]) ? 16'h0002 : 16'h0001);
        check({15'h0000, be}, 16'h0000);
    endtask : rd_chk

    // Words are programmed only while erased
    task automatic prog(logic b, logic [15:0] a, logic [15:0] d);
        logic ok;
        host.step(b, a, d, CMD_PROGRAM);
        mem[{b, a}] = d[15:8];
        mem[{b, a} + 1] = d[7:0];
        progq.push_back({b, a});
        host.wait_idle(b, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask : prog

    task automatic clr_err();
        @(negedge mclk_i) err_clr_i = 1'b1;
        @(negedge mclk_i) err_clr_i = 1'b0;
        check({15'h0000, aerr}, 16'h0000);
    endtask : clr_err

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        miscompares++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [15:0] d;
        logic be, ok;
        int lat, d0;
        void'($urandom(32'h3f60e15d));
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i) rst_n_i = 1'b1;
        check({sbe, eirq, aerr, sbusy}, 16'h000C);
        $display("test reset done");
        // Both arrays erased together; a busy array refuses reads
        host.step(1'b0, 16'h0000, 16'h0000, CMD_MASS);
        host.step(1'b1, 16'h0000, 16'h0000, CMD_MASS);
        check({15'h0000, sbusy}, 16'h0001);
        host.rd(17'h00010, 1'b1, d, be, lat);
        check(d, ERASED_WORD);
        check({15'h0000, be}, 16'h0001);
        host.wait_idle(1'b0, ok);
        host.wait_idle(1'b1, ok);
        check(16'(done_seen), 16'h0002);
        rd_chk(17'h1FFFC, 1'b1);
        $display("test concurrent erase done");
        // Random programs in both arrays, then aligned word, odd word and odd byte reads
        d0 = done_seen;
        for (int i = 0; i < 12; i++) prog(i[0], 16'(i * 4096 + ($urandom % 2048) * 2), 16'($urandom));
        check(16'(done_seen - d0), 16'h000C);
        foreach (progq[j]) begin
            rd_chk(progq[j], 1'b1);
            rd_chk(progq[j] + 1, 1'b1);
            rd_chk(progq[j] + 1, 1'b0);
        end
        $display("test program and read done");
        // One command queued behind another, a third refused
        host.step(1'b0, 16'hE000, 16'h1234, CMD_PROGRAM);
        host.step(1'b0, 16'hE002, 16'h5678, CMD_PROGRAM);
        check({sbe, eirq}, 16'h0000);
        host.step(1'b0, 16'hE004, 16'h0000, CMD_PROGRAM);
        check({15'h0000, aerr}, 16'h0001);
        for (int i = 0; i < 40 && sbe !== 1'b1; i++) @(negedge mclk_i);
        check({sbe, sbusy}, 16'h0003);
        host.wait_idle(1'b0, ok);
        {mem[32'hE000], mem[32'hE001], mem[32'hE002], mem[32'hE003]} = 32'h12345678;
        rd_chk(32'hE000, 1'b1);
        rd_chk(32'hE002, 1'b1);
        rd_chk(32'hE004, 1'b1);
        clr_err();
        // Steps out of order and an unknown code
        host.lone(CMD_SECTOR);
        check({15'h0000, aerr}, 16'h0001);
        clr_err();
        host.step(1'b0, 16'hE000, 16'h0000, 8'h77);
        check({15'h0000, aerr}, 16'h0001);
        clr_err();
        rd_chk(32'hE000, 1'b1);
        $display("test queue and refusal done");
        // Sector erase clears one aligned 512 byte group only
        prog(1'b1, 16'h0600, 16'hA5A5);
        prog(1'b1, 16'h07FE, 16'h0F0F);
        prog(1'b1, 16'h05FE, 16'h3C3C);
        prog(1'b1, 16'h0800, 16'h1111);
        host.step(1'b1, 16'h0700, 16'h0000, CMD_SECTOR);
        host.wait_idle(1'b1, ok);
        for (int k = 32'h10600; k < 32'h10800; k++) mem.delete(k);
        rd_chk(32'h10600, 1'b1);
        rd_chk(32'h107FE, 1'b1);
        rd_chk(32'h105FE, 1'b1);
        rd_chk(32'h10800, 1'b1);
        $display("test sector erase done");
        // Erase verify on a blank and a written array
        host.step(1'b1, 16'h0000, 16'h0000, CMD_MASS);
        host.wait_idle(1'b1, ok);
        host.step(1'b1, 16'h0000, 16'h0000, CMD_VERIFY);
        host.wait_idle(1'b1, ok);
        check({15'h0000, svok}, 16'h0001);
        host.step(1'b0, 16'h0000, 16'h0000, CMD_VERIFY);
        host.wait_idle(1'b0, ok);
        check({15'h0000, svok}, 16'h0000);
        $display("test verify done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
